/* File: inc/isc_pkg.sv */
/*
 * Package for the isolated serial channel logic: timing counts, packet
 * layout and state enumerations.
 * Assumes a 50 MHz system clock; all counts derive from that rate.
 */
`default_nettype none
package isc_pkg;
    localparam int CLK_PERIOD_NS  = 20;
    // Narrow pulse width limit on filtered fast paths
    localparam int GLITCH_NS      = 10;
    localparam int GLITCH_CYC     = (GLITCH_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
    // Slow channel sample to output latency
    localparam int UPDATE_NS      = 100;
    localparam int UPDATE_CYC     = UPDATE_NS / CLK_PERIOD_NS;
    // Packet pacing interval of the free running internal clock
    localparam int PACE_NS        = 400;
    localparam int PACE_CYC       = PACE_NS / CLK_PERIOD_NS;
    // Refresh after this long without a fast input transition
    localparam int REFRESH_NS     = 1200;
    localparam int REFRESH_CYC    = REFRESH_NS / CLK_PERIOD_NS;
    // Watchdog timeout without slow path traffic
    localparam int WDOG_NS        = 5000;
    localparam int WDOG_CYC       = WDOG_NS / CLK_PERIOD_NS;
    localparam int PKT_BITS       = 5;
    localparam logic [4:0] SEL_IDLE = 5'h01;

    typedef struct packed {
        logic slow;
        logic sel;
        logic data;
        logic clk;
        logic ret;
    } isc_pkt_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_UPDATE
    } isc_state_e;
endpackage
`default_nettype wire

/* File: rtl/isc_fifo.sv */
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes a single clock and an active high asynchronous reset.
 */
`timescale 1ns/10ps
`default_nettype none
module isc_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_i,     // Clock
    input  wire logic             rst_i,     // Reset
    input  wire logic             in_valid_i, // Write valid
    output logic                  in_ready_o, // Not full
    input  wire logic [WIDTH-1:0] in_data_i, // Write data
    output logic                  out_valid_o, // Not empty
    input  wire logic             out_ready_i, // Read accept
    output logic      [WIDTH-1:0] out_data_o // Read data
);
    localparam int AW = $clog2(DEPTH);
    if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_size
        $error("FIFO size not supported");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             do_wr;
    logic             do_rd;

    assign in_ready_o  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
    assign out_valid_o = wr_ptr != rd_ptr;
    assign do_wr       = in_valid_i && in_ready_o;
    assign do_rd       = out_valid_o && out_ready_i;
    assign out_data_o  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk_i) begin
        if (do_wr)
            mem[wr_ptr[AW-1:0]] <= in_data_i;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_wr)
                wr_ptr <= wr_ptr + 1'b1;
            if (do_rd)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule // isc_fifo
`default_nettype wire

/* File: rtl/isc_channel.sv */
/*
 * Channel logic of an isolated serial peripheral link: four fast paths,
 * two slow paths shuttled as packets, a delayed clock copy.
 * Assumes all pin inputs are asynchronous to CLK_I and pass synchronisers;
 * the barrier is modelled by an internal packet FIFO.
 */
`timescale 1ns/10ps
`default_nettype none
module isc_channel
    import isc_pkg::*;
#(
    parameter bit FILTERED  = 1'b1,
    parameter int DELAYED_CLOCK_OUT_TAPS = 2,
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic CLK_I,                  // System clock
    input  wire logic RST_I,                  // Async reset, high
    input  wire logic MASTER_CLK_I,           // Master serial clock
    input  wire logic MASTER_DATA_IN_I,       // Master data in
    input  wire logic MASTER_SELECT_IN_I,     // Master select, low active
    output logic      MASTER_RETURN_OUT_O,    // Data back to master
    output logic      DELAYED_CLOCK_OUT_O,    // Delayed clock copy
    input  wire logic SLOW_IN_A_I,            // Slow input, master side
    output logic      SLOW_OUT_B_O,           // Slow output, master side
    output logic      SLOW_OUT_B_OE_N_O,      // Enable, low drives
    output logic      SLAVE_CLK_O,            // Serial clock to slave
    output logic      SLAVE_DATA_O,           // Data to slave
    output logic      SLAVE_SELECT_OUT_N_O,   // Select to slave, low active
    output logic      SLAVE_OE_N_O,           // Slave side enable, low drives
    input  wire logic SLAVE_DATA_I,           // Data from slave
    input  wire logic SLOW_IN_B_I,            // Slow input, slave side
    output logic      SLOW_OUT_A_O,           // Slow output, slave side
    output logic      SLOW_OUT_A_OE_N_O,      // Enable, low drives
    output logic      LINK_FAULT_O            // Watchdog expired or select mismatch
);
    default clocking cb_sys @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    if (DELAYED_CLOCK_OUT_TAPS < 1 || DELAYED_CLOCK_OUT_TAPS > 16) begin : g_bad_taps
        $error("DELAYED_CLOCK_OUT_TAPS out of range");
    end

    // Synchronisers for the asynchronous pins
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] pins;
    assign pins = {SLOW_IN_B_I, SLOW_IN_A_I, SLAVE_DATA_I,
                   MASTER_SELECT_IN_I, MASTER_CLK_I ^ 1'b0};

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            sync1 <= SEL_IDLE << 1;
            sync2 <= SEL_IDLE << 1;
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
        end
    end

    logic mclk_s, msel_s, sdat_s, slow_a_s, slow_b_s;
    logic mdat1, mdat2;
    assign mclk_s   = sync2[0];
    assign msel_s   = sync2[1];
    assign sdat_s   = sync2[2];
    assign slow_a_s = sync2[3];
    assign slow_b_s = sync2[4];

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            mdat1 <= 1'b0;
            mdat2 <= 1'b0;
        end else begin
            mdat1 <= MASTER_DATA_IN_I;
            mdat2 <= mdat1;
        end
    end

    // Glitch filter: level must hold GLITCH_CYC+1 samples
    localparam int GW = GLITCH_CYC + 1;
    logic [3:0]    f_in;
    logic [3:0]    f_out;
    logic [GW-1:0] f_hist [4];
    assign f_in = {msel_s, sdat_s, mdat2, mclk_s};

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            for (int i = 0; i < 4; i++)
                f_hist[i] <= (i == 3) ? {GW{1'b1}} : '0;
            f_out <= 4'h8;
        end else begin
            for (int i = 0; i < 4; i++) begin
                f_hist[i] <= {f_hist[i][GW-2:0], f_in[i]};
                if (f_hist[i] == {GW{1'b1}})
                    f_out[i] <= 1'b1;
                else if (f_hist[i] == {GW{1'b0}})
                    f_out[i] <= 1'b0;
            end
        end
    end

    // Grade selection; select is filtered in both grades
    logic clk_p, mdat_p, sdat_p, sel_p;
    assign clk_p  = FILTERED ? f_out[0] : mclk_s;
    assign mdat_p = FILTERED ? f_out[1] : mdat2;
    assign sdat_p = FILTERED ? f_out[2] : sdat_s;
    assign sel_p  = f_out[3];

    // Refresh counter, restarts on any fast transition
    logic [3:0]  fast_prev;
    logic [15:0] idle_cnt;
    logic        refresh;
    assign refresh = idle_cnt == 16'(REFRESH_CYC - 1);

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            fast_prev <= 4'h8;
            idle_cnt  <= '0;
        end else begin
            fast_prev <= {sel_p, sdat_p, mdat_p, clk_p};
            if (fast_prev != {sel_p, sdat_p, mdat_p, clk_p} || refresh)
                idle_cnt <= '0;
            else
                idle_cnt <= idle_cnt + 16'h0001;
        end
    end

    // Fast paths: registered level forwarding every cycle, not gated by refresh
    logic slv_clk, slv_dat, slv_sel, mst_ret;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            slv_clk <= 1'b0;
            slv_dat <= 1'b0;
            slv_sel <= 1'b1;
            mst_ret <= 1'b0;
        end else begin
            slv_clk <= clk_p;
            slv_dat <= mdat_p;
            slv_sel <= sel_p;
            mst_ret <= sdat_p;
        end
    end
    assign SLAVE_CLK_O          = slv_clk;
    assign SLAVE_DATA_O         = slv_dat;
    assign SLAVE_SELECT_OUT_N_O = slv_sel;
    assign MASTER_RETURN_OUT_O  = mst_ret;

    // Delayed clock: matches clock path plus return path
    logic [DELAYED_CLOCK_OUT_TAPS-1:0] dly;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I)
            dly <= '0;
        else
            dly <= DELAYED_CLOCK_OUT_TAPS'({dly, slv_clk});
    end
    assign DELAYED_CLOCK_OUT_O = dly[DELAYED_CLOCK_OUT_TAPS-1];

    // Pace clock for slow packet shuttle
    logic [7:0] pace_cnt;
    logic       pace;
    assign pace = pace_cnt == 8'(PACE_CYC - 1);
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I)
            pace_cnt <= '0;
        else if (pace)
            pace_cnt <= '0;
        else
            pace_cnt <= pace_cnt + 8'h01;
    end

    // Direction toggles each exchange: 0 master to slave, 1 back
    logic     dir;
    isc_pkt_s snap;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I)
            dir <= 1'b0;
        else if (pace)
            dir <= ~dir;
    end
    always_comb begin
        snap.clk  = clk_p;
        snap.data = mdat_p;
        snap.sel  = sel_p;
        snap.ret  = sdat_p;
        snap.slow = dir ? slow_b_s : slow_a_s;
    end

    // Barrier buffer
    logic     tx_ready, rx_valid, rx_take;
    isc_pkt_s rx_pkt;
    isc_fifo #(.WIDTH(PKT_BITS), .DEPTH(FIFO_DEPTH)) u_barrier (
        .clk_i       (CLK_I),
        .rst_i       (RST_I),
        .in_valid_i  (pace),
        .in_ready_o  (tx_ready),
        .in_data_i   (snap),
        .out_valid_o (rx_valid),
        .out_ready_i (rx_take),
        .out_data_o  (rx_pkt)
    );

    // Receiver: wait UPDATE_CYC then apply the packet
    isc_state_e state;
    logic [7:0] upd_cnt;
    logic       rx_dir;
    logic       mismatch;
    assign rx_take = state == ST_IDLE && rx_valid;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state   <= ST_IDLE;
            upd_cnt <= '0;
            rx_dir  <= 1'b1;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (rx_valid) begin
                        state   <= ST_SHIFT;
                        upd_cnt <= '0;
                        rx_dir  <= ~rx_dir;
                    end
                end
                ST_SHIFT: begin
                    upd_cnt <= upd_cnt + 8'h01;
                    if (upd_cnt == 8'(UPDATE_CYC - 2))
                        state <= ST_UPDATE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    logic       slow_a_q, slow_b_q;
    isc_pkt_s   held;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            held     <= '0;
            slow_a_q <= 1'b0;
            slow_b_q <= 1'b0;
            mismatch <= 1'b0;
        end else begin
            if (rx_take)
                held <= rx_pkt;
            if (state == ST_UPDATE) begin
                mismatch <= held.sel != slv_sel;
                if (rx_dir)
                    slow_b_q <= held.slow;
                else
                    slow_a_q <= held.slow;
            end
        end
    end
    assign SLOW_OUT_A_O = slow_a_q;
    assign SLOW_OUT_B_O = slow_b_q;

    // Watchdog on slow traffic
    logic [15:0] wd_cnt;
    logic        fault;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            wd_cnt <= '0;
            fault  <= 1'b0;
        end else if (rx_take) begin
            wd_cnt <= '0;
            fault  <= 1'b0;
        end else if (wd_cnt == 16'(WDOG_CYC - 1)) begin
            fault  <= 1'b1;
        end else begin
            wd_cnt <= wd_cnt + 16'h0001;
        end
    end
    assign SLOW_OUT_A_OE_N_O = fault;
    assign SLOW_OUT_B_OE_N_O = fault;
    assign SLAVE_OE_N_O      = fault;
    assign LINK_FAULT_O      = fault | mismatch;

    // Checks
    int unsigned upd_lat;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I)
            upd_lat <= 0;
        else if (rx_take)
            upd_lat <= 0;
        else
            upd_lat <= upd_lat + 1;
    end

    pace_period_a: assert property (pace |=> !pace [*8])
        else $error("pace too fast");
    sel_follow_a: assert property ($stable(MASTER_SELECT_IN_I) [*8]
        |=> SLAVE_SELECT_OUT_N_O == $past(MASTER_SELECT_IN_I))
        else $error("select lost");
    ret_follow_a: assert property ($stable(SLAVE_DATA_I) [*8]
        |=> MASTER_RETURN_OUT_O == $past(SLAVE_DATA_I))
        else $error("return lost");
    delayed_clock_out_delay_a: assert property (
        DELAYED_CLOCK_OUT_O == $past(SLAVE_CLK_O, DELAYED_CLOCK_OUT_TAPS))
        else $error("delayed_clock_out bad");
    update_time_a: assert property (
        rx_take |-> ##[1:5] state == ST_UPDATE) else $error("slow late");
    update_exact_a: assert property (
        state == ST_UPDATE |-> upd_lat == UPDATE_CYC - 1)
        else $error("slow update time wrong");
    refresh_wrap_a: assert property (refresh |=> idle_cnt == 0)
        else $error("refresh stuck");
    refresh_level_a: assert property (refresh |->
        {slv_sel, mst_ret, slv_dat, slv_clk} == {sel_p, sdat_p, mdat_p, clk_p})
        else $error("steady level wrong");
    wdog_fire_a: assert property (
        wd_cnt == 16'(WDOG_CYC - 1) && !rx_take |=> SLOW_OUT_A_OE_N_O)
        else $error("watchdog silent");
    fifo_room_a: assert property (pace |-> tx_ready)
        else $error("packet buffer full");
    fast_follow_a: assert property ($stable(MASTER_CLK_I) [*8]
        |=> SLAVE_CLK_O == $past(MASTER_CLK_I))
        else $error("clock lost");
    cov_fault_c: cover property (@(posedge CLK_I) $rose(fault));
    cov_update_c: cover property (@(posedge CLK_I) state == ST_UPDATE);
    cov_sel_c: cover property (@(posedge CLK_I) $fell(slv_sel));
endmodule // isc_channel
`default_nettype wire

/* File: sim/isc_spi_slave.sv */
/*
 * Behavioural serial peripheral slave for the channel bench.
 * Assumes it sees only the slave side outputs of the channel.
 */
`timescale 1ns/10ps
`default_nettype none
module isc_spi_slave (
    input  wire logic       clk_i,   // System clock
    input  wire logic       rst_i,   // Reset
    input  wire logic       sclk_i,  // Serial clock
    input  wire logic       mosi_i,  // Data from master
    input  wire logic       sel_n_i, // Select, low active
    input  wire logic [7:0] tx_i,    // Byte to return
    output logic            miso_o,  // Data to master
    output logic      [7:0] rx_o     // Last byte received
);
    logic       sclk_q;
    logic       sel_q;
    logic [7:0] shift;
    logic [7:0] rx;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_q <= 1'b0;
            sel_q  <= 1'b1;
            shift  <= 8'h00;
            rx     <= 8'h00;
            rx_o   <= 8'h00;
            miso_o <= 1'b0;
        end else begin
            sclk_q <= sclk_i;
            sel_q  <= sel_n_i;
            if (sel_q && !sel_n_i) begin
                shift  <= tx_i;
                miso_o <= tx_i[7];
            end else if (!sel_n_i && !sclk_q && sclk_i) begin
                rx <= {rx[6:0], mosi_i};
            end else if (!sel_n_i && sclk_q && !sclk_i) begin
                shift  <= {shift[6:0], 1'b0};
                miso_o <= shift[6];
            end else if (!sel_q && sel_n_i) begin
                rx_o   <= rx;
                // Released line shows the inverse of its last level
                miso_o <= ~miso_o;
            end
        end
    end
endmodule // isc_spi_slave
`default_nettype wire

/* File: sim/isolated_spi_channel_logic_tb_top.sv */
/*
 * Self-checking bench for the channel: bench acts as master, a slave
 * model stands on the far side. Assumes unfiltered grade timing.
 */
`timescale 1ns/10ps
`default_nettype none
module isolated_spi_channel_logic_tb_top;
    import isc_pkg::*;
    logic        clk, rst, m_clk, m_data, m_sel, s_in_a, s_in_b;
    logic        mro, delayed_clock_out, so_b, so_b_oe, s_clk, s_data, s_sel;
    logic        s_oe, miso, so_a, so_a_oe, fault, delayed_clock_out_q;
    logic [7:0]  s_tx, s_rx, m_rx;
    logic [31:0] rnd;
    int          err_count, comparisons, cycles;
    logic [7:0]  exp_s[$];
    logic [7:0]  exp_m[$];

    isc_channel #(.FILTERED(1'b0), .DELAYED_CLOCK_OUT_TAPS(2), .FIFO_DEPTH(16)) u_dut (
        .CLK_I(clk), .RST_I(rst), .MASTER_CLK_I(m_clk),
        .MASTER_DATA_IN_I(m_data), .MASTER_SELECT_IN_I(m_sel),
        .MASTER_RETURN_OUT_O(mro), .DELAYED_CLOCK_OUT_O(delayed_clock_out),
        .SLOW_IN_A_I(s_in_a), .SLOW_OUT_B_O(so_b),
        .SLOW_OUT_B_OE_N_O(so_b_oe), .SLAVE_CLK_O(s_clk),
        .SLAVE_DATA_O(s_data), .SLAVE_SELECT_OUT_N_O(s_sel),
        .SLAVE_OE_N_O(s_oe), .SLAVE_DATA_I(miso), .SLOW_IN_B_I(s_in_b),
        .SLOW_OUT_A_O(so_a), .SLOW_OUT_A_OE_N_O(so_a_oe),
        .LINK_FAULT_O(fault));

    isc_spi_slave u_slave (.clk_i(clk), .rst_i(rst), .sclk_i(s_clk),
        .mosi_i(s_data), .sel_n_i(s_sel), .tx_i(s_tx), .miso_o(miso),
        .rx_o(s_rx));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic cmp_bit(input string what, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic cmp_byte(input string what, input logic [7:0] e,
                            input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Mode 0 frame, 160 ns serial clock standing low outside frames
    task automatic spi_frame(input logic [7:0] mtx, input logic [7:0] stx);
        int i;
        s_tx <= stx;
        exp_s.push_back(mtx);
        exp_m.push_back(stx);
        @(posedge clk);
        m_sel  <= 1'b0;
        m_data <= mtx[7];
        repeat (8) @(posedge clk);
        for (i = 7; i >= 0; i--) begin
            m_clk <= 1'b1;
            repeat (4) @(posedge clk);
            m_clk <= 1'b0;
            if (i > 0)
                m_data <= mtx[i-1];
            repeat (4) @(posedge clk);
        end
        repeat (8) @(posedge clk);
        m_sel <= 1'b1;
        repeat (12) @(posedge clk);
        @(negedge clk);
        cmp_byte("slave_rx", exp_s.pop_front(), s_rx);
        cmp_byte("master_rx", exp_m.pop_front(), m_rx);
    endtask

    task automatic slow_case(input logic v);
        int n;
        @(posedge clk);
        s_in_a <= v;
        s_in_b <= ~v;
        n = 0;
        while (n < 130 && (so_a !== v || so_b !== ~v)) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        cmp_bit("slow_out_a", v, so_a);
        cmp_bit("slow_out_b", ~v, so_b);
        repeat (100) @(negedge clk);
        cmp_bit("slow_out_a_held", v, so_a);
        cmp_bit("slow_oe_a", 1'b0, so_a_oe);
        cmp_bit("slow_oe_b", 1'b0, so_b_oe);
        cmp_bit("slave_oe", 1'b0, s_oe);
        cmp_bit("link_fault", 1'b0, fault);
    endtask

    // Master side capture on the delayed clock
    always @(posedge clk) begin
        delayed_clock_out_q <= delayed_clock_out;
        if (delayed_clock_out && !delayed_clock_out_q && !m_sel)
            m_rx <= {m_rx[6:0], mro};
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        rst = 1'b1; m_clk = 1'b0; m_data = 1'b0; m_sel = 1'b1;
        s_in_a = 1'b0; s_in_b = 1'b0; s_tx = 8'h00; m_rx = 8'h00;
        delayed_clock_out_q = 1'b0; rnd = 32'h33B4B3CC;
        err_count = 0; comparisons = 0; cycles = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        cmp_bit("select_reset", 1'b1, s_sel);
        cmp_bit("fault_reset", 1'b0, fault);
        $display("test reset done");
        repeat (24) begin
            @(posedge clk);
            rnd = lfsr_next(rnd);
            m_clk  <= rnd[0];
            m_data <= rnd[1];
            repeat (8) @(posedge clk);
            @(negedge clk);
            cmp_bit("slave_clk", rnd[0], s_clk);
            cmp_bit("slave_data", rnd[1], s_data);
            cmp_bit("delayed_clk", rnd[0], delayed_clock_out);
            cmp_bit("select_idle", 1'b1, s_sel);
        end
        @(posedge clk);
        m_clk <= 1'b0;
        repeat (8) @(posedge clk);
        $display("test fast levels done");
        spi_frame(8'h00, 8'hFF);
        spi_frame(8'hFF, 8'h00);
        repeat (4) begin
            rnd = lfsr_next(rnd);
            spi_frame(rnd[7:0], rnd[15:8]);
        end
        $display("test frames done");
        @(posedge clk);
        m_sel <= 1'b0;
        @(posedge clk);
        m_sel <= 1'b1;
        repeat (10) begin
            @(negedge clk);
            cmp_bit("select_glitch", 1'b1, s_sel);
        end
        cmp_bit("return_driven", miso, mro);
        $display("test select filter done");
        slow_case(1'b1);
        slow_case(1'b0);
        $display("test slow channels done");
        final_report();
    end
endmodule // isolated_spi_channel_logic_tb_top
`default_nettype wire
